/* rtl/dars_regs.svh */
/*
  register offsets, bit positions and numeric constants of the alu block.
  assumes inclusion by bare name from the alu module.
*/
`ifndef DARS_REGS_SVH
`define DARS_REGS_SVH
// register word offsets on the plain register port
`define DARS_OFF_MODE 8'h00
`define DARS_OFF_ARITH_STATUS 8'h04
`define DARS_OFF_STICKY_STATUS 8'h08
// mode_control_reg bits
`define DARS_B_SAT 13
`define DARS_B_ROUND_TO_ZERO_SELECT 15
`define DARS_B_NARROW 16
// arith_status_reg bits
`define DARS_B_AZ 0
`define DARS_B_AV 1
`define DARS_B_AN 2
`define DARS_B_AC 3
`define DARS_B_AS 4
`define DARS_B_AI 5
`define DARS_B_AF 10
`define DARS_COMPARE_HISTORY_HI 31
`define DARS_COMPARE_HISTORY_LO 24
`define DARS_ARITH_STATUS_MASK 32'hFF00_043F
// sticky_status_reg bits
`define DARS_B_AUS 0
`define DARS_B_AVS 1
`define DARS_B_AOS 2
// fixed-point limits and field padding
`define DARS_FIX_MAX 32'h7FFF_FFFF
`define DARS_FIX_MIN 32'h8000_0000
`define DARS_LOW8 8'h00
// float format figures
`define DARS_BIAS 10'h07F
`define DARS_EXP_TOP 10'h0FF
`define DARS_EXP_MAXF 8'hFE
`define DARS_FRAC_MAX 31'h7FFF_FFFF
`define DARS_FRAC_N32 31'h7FFF_FF00
`define DARS_NAN 40'hFF_FFFF_FFFF
`define DARS_FLT_EXP 10'h09E
`define DARS_LSB_N32 34'h0_0000_0400
`define DARS_LSB_W40 34'h0_0000_0004
`endif

/* rtl/dars_pkg.sv */
/*
  types of the alu block: operations, request, answer, state.
  assumes the constants header is on the include path.
*/
`default_nettype none
package dars_pkg;
  // operations the sequencer may issue
  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_ADDSUB, OP_COMP, OP_AND, OP_OR, OP_XOR, OP_PASS, OP_ABS,
    OP_FADD, OP_FSUB, OP_FCOMP, OP_FPASS, OP_RND, OP_FLOAT, OP_SIGNIFICAND_EXTRACT_OP, OP_BINARY_LOG_OP, OP_FRND
  } dars_op_e;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dars_bus_s;
  // one alu operation with its two operands
  typedef struct packed {
    logic valid;
    dars_op_e op;
    logic [39:0] x;
    logic [39:0] y;
  } dars_req_s;
  // result write-back toward the register file
  typedef struct packed {
    logic wr_a;
    logic wr_b;
    logic [39:0] res_a;
    logic [39:0] res_b;
  } dars_rsp_s;
  // mode bits kept by the block
  typedef struct packed {
    logic sat;
    logic round_to_zero_select;
    logic nar;
  } dars_mode_s;
  // arithmetic status flags
  typedef struct packed {
    logic [7:0] compare_history;
    logic af;
    logic ai;
    logic as;
    logic ac;
    logic an;
    logic av;
    logic az;
  } dars_flags_s;
  // float result with its exception bits
  typedef struct packed {
    logic [39:0] v;
    logic ovf;
    logic unf;
    logic inv;
  } dars_fres_s;
  // whole state of the alu
  typedef struct packed {
    dars_mode_s mode;
    dars_flags_s fl;
    logic [2:0] sticky_status;
    dars_rsp_s rsp;
    logic [31:0] rdata;
  } dars_state_s;
endpackage : dars_pkg
`default_nettype wire

/* rtl/dars_alu.sv */
/*
  alu with rounding, mode and status registers.
  assumes operands come combinationally from the register file and that the
  register file writes rsp one edge later; registers reached by a plain port.
*/
// The implementer's own choices: the address map and strobed register access.
// Behaviour
// - fixed operands upper 32 bits, low 8 zeroed
// - round-to-zero truncates below destination precision
// - nearest rounding, ties go to even
// - halfway above max finite rounds to infinity
// - mode bits: saturate 13, truncate 15, narrow 16
// - fractional product rounding is nearest only
// - one result, two for add/sub, compare none
// - read and write same location in one cycle
// - all fixed results left-justified, low byte clear
// - status treats fixed values as twos-complement
// - saturation clamps overflow to max or min
// - no saturation returns wrapped upper 32 bits, except fractional product rounding clamps to max
// - overflow flag reflects unsaturated result
// - narrow mode zeroes input and result low byte, except round op input and fixed-to-float result
// - wide mode uses and writes all 40 bits, except the round op result
// - fixed-to-float always rounds at 40 bits
// - seven status flags updated every operation
// - compare history updated on every compare
// - sticky flags set only, software clears them
// - flags visible next cycle, software write wins
// - history shifts down, top bit gets x>y
`include "dars_regs.svh"
`default_nettype none
module dars_alu (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire dars_pkg::dars_bus_s bus,
  output logic [31:0] reg_rdata,
  input wire dars_pkg::dars_req_s req,
  output dars_pkg::dars_rsp_s rsp
);
  import dars_pkg::*;

  dars_state_s st_q; // all registered state
  dars_state_s st_d; // its next value

  // fixed operand taken from the upper 32 bits
  function automatic logic [31:0] fx_in(input logic [39:0] v);
    return v[39:8];
  endfunction : fx_in

  // fixed result placed high, low byte cleared
  function automatic logic [39:0] fx_out(input logic [31:0] v);
    return {v, `DARS_LOW8};
  endfunction : fx_out

  // leading zero count of a 32-bit word
  function automatic logic [5:0] lzc(input logic [31:0] v);
    logic [5:0] n;
    logic hit;
    n = 6'h20;
    hit = 1'h0;
    for (int i = 31; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n = 6'(31 - i);
        hit = 1'h1;
      end
    end
    return n;
  endfunction : lzc

  // right shift keeping a sticky bit
  function automatic logic [33:0] shr_st(input logic [33:0] v, input logic [9:0] d);
    logic [33:0] m;
    logic lost;
    if (d > 10'h021) begin
      return {33'h0, |v};
    end
    m = v >> d;
    lost = |(v & ((34'h1 << d) - 34'h1));
    return {m[33:1], m[0] | lost};
  endfunction : shr_st

  // saturate a fixed overflow toward the sign of x
  function automatic logic [31:0] satf(input logic [31:0] r, input logic ovf,
                                       input logic xneg, input logic en);
    if (ovf && en) begin
      return xneg ? `DARS_FIX_MIN : `DARS_FIX_MAX;
    end
    return r;
  endfunction : satf

  // float classification; denormals count as zero
  function automatic logic f_zero(input logic [39:0] v);
    return v[38:31] == 8'h00;
  endfunction : f_zero

  function automatic logic f_nan(input logic [39:0] v);
    return v[38:31] == `DARS_EXP_TOP && v[30:0] != 31'h0;
  endfunction : f_nan

  function automatic logic f_inf(input logic [39:0] v);
    return v[38:31] == `DARS_EXP_TOP && v[30:0] == 31'h0;
  endfunction : f_inf

  // float mapped onto a signed ordering for compare
  function automatic logic signed [40:0] f_ord(input logic [39:0] v);
    logic [40:0] m;
    m = f_zero(v) ? 41'h0 : {2'h0, v[38:0]};
    return v[39] ? $signed(41'h0 - m) : $signed(m);
  endfunction : f_ord

  // round a normalised significand and pack it
  // sig: hidden bit 33, fraction 32:2, guard 1, sticky 0
  function automatic dars_fres_s rpack(input logic s, input logic signed [9:0] e,
                                       input logic [33:0] sig, input logic nar, input logic trn);
    dars_fres_s r;
    logic [33:0] unit;
    logic [33:0] base;
    logic g;
    logic stk;
    logic lsb;
    logic up;
    logic [34:0] rs;
    logic signed [9:0] ee;
    r = '0;
    unit = nar ? `DARS_LSB_N32 : `DARS_LSB_W40;
    g = nar ? sig[9] : sig[1];
    stk = nar ? |sig[8:0] : sig[0];
    lsb = nar ? sig[10] : sig[2];
    // dropping bits below the lsb is the truncation
    base = nar ? {sig[33:10], 10'h000} : {sig[33:2], 2'h0};
    // above half, or exactly half with odd lsb
    up = !trn && g && (stk || lsb);
    rs = {1'h0, base} + {1'h0, up ? unit : 34'h0};
    ee = e;
    if (rs[34]) begin
      rs = rs >> 1;
      ee = e + 10'sh001;
    end
    // a carry out of max finite lands on infinity
    if (ee >= $signed(`DARS_EXP_TOP)) begin
      r.ovf = 1'h1;
      r.v = trn ? {s, `DARS_EXP_MAXF, nar ? `DARS_FRAC_N32 : `DARS_FRAC_MAX}
                : {s, 8'(`DARS_EXP_TOP), 31'h0};
    end else if (ee <= 10'sh000) begin
      r.unf = 1'h1; // flushed to signed zero
      r.v = {s, 39'h0};
    end else begin
      r.v = {s, ee[7:0], rs[32:2]};
    end
    return r;
  endfunction : rpack

  // float add of a and b, both already narrowed if needed
  function automatic dars_fres_s fadd(input logic [39:0] a, input logic [39:0] b,
                                      input logic nar, input logic trn);
    dars_fres_s r;
    logic [39:0] big;
    logic [39:0] sml;
    logic [9:0] d;
    logic [33:0] sb;
    logic [33:0] ss;
    logic [34:0] sum;
    logic [5:0] lz;
    logic signed [9:0] e;
    r = '0;
    big = a;
    sml = b;
    sb = '0;
    ss = '0;
    sum = '0;
    lz = '0;
    e = '0;
    d = '0;
    if (f_nan(a) || f_nan(b) || (f_inf(a) && f_inf(b) && a[39] != b[39])) begin
      r.inv = 1'h1; // quiet nan, all ones
      r.v = `DARS_NAN;
    end else if (f_inf(a)) begin
      r.v = a;
    end else if (f_inf(b)) begin
      r.v = b;
    end else if (f_zero(a) && f_zero(b)) begin
      r.v = {a[39] & b[39], 39'h0};
    end else if (f_zero(b)) begin
      r.v = a;
    end else if (f_zero(a)) begin
      r.v = b;
    end else begin
      // larger magnitude decides sign and exponent
      if (a[38:0] < b[38:0]) begin
        big = b;
        sml = a;
      end
      d = {2'h0, big[38:31]} - {2'h0, sml[38:31]};
      sb = {1'h1, big[30:0], 2'h0};
      ss = shr_st({1'h1, sml[30:0], 2'h0}, d);
      e = $signed({2'h0, big[38:31]});
      if (big[39] == sml[39]) begin
        sum = {1'h0, sb} + {1'h0, ss};
        if (sum[34]) begin
          sb = {sum[34:2], sum[1] | sum[0]};
          e = e + 10'sh001;
        end else begin
          sb = sum[33:0];
        end
        r = rpack(big[39], e, sb, nar, trn);
      end else begin
        sum = {1'h0, sb} - {1'h0, ss};
        if (sum == 35'h0) begin
          r.v = 40'h0; // exact cancel gives plus zero
        end else begin
          lz = lzc(sum[33:2]);
          sb = sum[33:0] << lz;
          e = e - $signed({4'h0, lz});
          r = rpack(big[39], e, sb, nar, trn);
        end
      end
    end
    return r;
  endfunction : fadd

  // read view of the status word
  function automatic logic [31:0] arith_status_word(input dars_flags_s f);
    logic [31:0] w;
    w = 32'h0;
    w[`DARS_COMPARE_HISTORY_HI:`DARS_COMPARE_HISTORY_LO] = f.compare_history;
    w[`DARS_B_AF] = f.af;
    w[`DARS_B_AI] = f.ai;
    w[`DARS_B_AS] = f.as;
    w[`DARS_B_AC] = f.ac;
    w[`DARS_B_AN] = f.an;
    w[`DARS_B_AV] = f.av;
    w[`DARS_B_AZ] = f.az;
    return w;
  endfunction : arith_status_word

  logic [39:0] xa; // float x after narrowing
  logic [39:0] ya; // float y after narrowing
  logic [31:0] fx; // fixed x
  logic [31:0] fy; // fixed y
  logic [32:0] ua; // fixed x+y with carry
  logic [32:0] us; // fixed x-y with carry
  logic ov_a; // add overflow, twos-complement
  logic ov_s; // sub overflow
  logic fix_gt; // signed x > y
  logic [31:0] r32; // fixed primary result
  logic [31:0] mag; // magnitude for int to float
  logic [5:0] lz; // its leading zeros
  logic [9:0] e10; // exponent arithmetic
  logic fop; // float-type operation
  logic fres; // result is float
  logic fovf; // fixed overflow before clamp
  logic up; // fractional product round-up
  dars_fres_s fr; // float result

  // operation, status and register update
  always_comb begin
    st_d = st_q;
    st_d.rsp.wr_a = 1'h0;
    st_d.rsp.wr_b = 1'h0;
    st_d.rdata = 32'h0;
    // operands are sampled combinationally, result is written at the edge,
    // so the same location may be source and destination
    fx = fx_in(req.x);
    fy = fx_in(req.y);
    xa = req.x;
    ya = req.y;
    if (st_q.mode.nar && req.op != OP_RND) begin
      xa[7:0] = `DARS_LOW8;
      ya[7:0] = `DARS_LOW8;
    end
    ua = {1'h0, fx} + {1'h0, fy};
    us = {1'h0, fx} + {1'h0, ~fy} + 33'h1;
    // sign flip of a like-signed sum is overflow
    ov_a = fx[31] == fy[31] && ua[31] != fx[31];
    ov_s = fx[31] != fy[31] && us[31] != fx[31];
    fix_gt = $signed(fx) > $signed(fy);
    r32 = 32'h0;
    mag = 32'h0;
    lz = 6'h0;
    e10 = 10'h0;
    fop = 1'h0;
    fres = 1'h0;
    fovf = 1'h0;
    up = 1'h0;
    fr = '0;
    if (req.valid) begin
      // every op rewrites the seven flags
      st_d.fl.az = 1'h0;
      st_d.fl.av = 1'h0;
      st_d.fl.an = 1'h0;
      st_d.fl.ac = 1'h0;
      st_d.fl.as = 1'h0;
      st_d.fl.ai = 1'h0;
      st_d.rsp.wr_a = 1'h1;
      case (req.op)
        OP_ADD, OP_ADDSUB: begin
          r32 = satf(ua[31:0], ov_a, fx[31], st_q.mode.sat);
          fovf = ov_a;
          st_d.fl.ac = ua[32];
          if (req.op == OP_ADDSUB) begin
            // second result of the dual op
            st_d.rsp.wr_b = 1'h1;
            st_d.rsp.res_b = fx_out(satf(us[31:0], ov_s, fx[31], st_q.mode.sat));
            fovf = ov_a | ov_s;
          end
        end
        OP_SUB: begin
          r32 = satf(us[31:0], ov_s, fx[31], st_q.mode.sat);
          fovf = ov_s;
          st_d.fl.ac = us[32];
        end
        OP_COMP, OP_FCOMP: begin
          // flags only, no write-back
          st_d.rsp.wr_a = 1'h0;
          fop = req.op == OP_FCOMP;
          if (fop) begin
            st_d.fl.az = f_ord(xa) == f_ord(ya);
            st_d.fl.an = f_ord(xa) < f_ord(ya);
            st_d.fl.ai = f_nan(xa) | f_nan(ya);
          end else begin
            st_d.fl.az = fx == fy;
            st_d.fl.an = $signed(fx) < $signed(fy);
          end
          // shift toward lsb, newest outcome on top
          st_d.fl.compare_history = {fop ? f_ord(xa) > f_ord(ya) : fix_gt, st_q.fl.compare_history[7:1]};
        end
        OP_AND: r32 = fx & fy;
        OP_OR: r32 = fx | fy;
        OP_XOR: r32 = fx ^ fy;
        OP_PASS: r32 = fx;
        OP_ABS: begin
          fovf = fx == `DARS_FIX_MIN;
          r32 = satf(fx[31] ? 32'h0 - fx : fx, fovf, 1'h0, st_q.mode.sat);
          st_d.fl.as = fx[31];
        end
        OP_FADD, OP_FSUB: begin
          fop = 1'h1;
          fres = 1'h1;
          fr = fadd(xa, {ya[39] ^ (req.op == OP_FSUB), ya[38:0]}, st_q.mode.nar, st_q.mode.round_to_zero_select);
        end
        OP_FPASS, OP_RND: begin
          // round op always targets the 32-bit boundary
          fop = 1'h1;
          fres = 1'h1;
          if (f_nan(xa)) begin
            fr.inv = 1'h1;
            fr.v = `DARS_NAN;
          end else if (f_zero(xa) || f_inf(xa)) begin
            fr.v = f_zero(xa) ? {xa[39], 39'h0} : xa;
          end else begin
            fr = rpack(xa[39], $signed({2'h0, xa[38:31]}), {1'h1, xa[30:0], 2'h0},
                       st_q.mode.nar | (req.op == OP_RND), st_q.mode.round_to_zero_select);
          end
        end
        OP_FLOAT: begin
          fop = 1'h1;
          fres = 1'h1;
          mag = fx[31] ? 32'h0 - fx : fx;
          lz = lzc(mag);
          if (mag != 32'h0) begin
            // boundary fixed at 40 bits whatever the mode
            fr = rpack(fx[31], $signed(`DARS_FLT_EXP - {4'h0, lz}), {mag << lz, 2'h0},
                       1'h0, st_q.mode.round_to_zero_select);
          end
        end
        OP_SIGNIFICAND_EXTRACT_OP: begin
          fop = 1'h1;
          r32 = f_zero(xa) ? 32'h0 : {1'h1, xa[30:0]};
          st_d.fl.as = xa[39];
          st_d.fl.ai = f_nan(xa);
        end
        OP_BINARY_LOG_OP: begin
          fop = 1'h1;
          e10 = {2'h0, xa[38:31]} - `DARS_BIAS;
          r32 = {{22{e10[9]}}, e10};
          if (f_zero(xa) || f_inf(xa)) begin
            r32 = f_zero(xa) ? `DARS_FIX_MIN : `DARS_FIX_MAX;
            st_d.fl.av = 1'h1;
          end
          st_d.fl.ai = f_nan(xa);
        end
        OP_FRND: begin
          // x high and y low word of a local product;
          // only nearest is done, truncation is just x
          up = fy[31] && (|fy[30:0] || fx[0]);
          fovf = up && fx == `DARS_FIX_MAX;
          r32 = fovf ? `DARS_FIX_MAX : fx + {31'h0, up};
        end
        default: st_d.rsp.wr_a = 1'h0;
      endcase
      st_d.fl.af = fop;
      if (fres) begin
        st_d.rsp.res_a = fr.v;
        // a nan of all ones must still come out with a clear low byte when narrow
        if ((st_q.mode.nar && req.op != OP_FLOAT) || req.op == OP_RND) st_d.rsp.res_a[7:0] = `DARS_LOW8;
        st_d.fl.az = f_zero(fr.v) | fr.unf;
        st_d.fl.an = fr.v[39] && !f_zero(fr.v) && !fr.inv;
        st_d.fl.av = fr.ovf;
        st_d.fl.ai = fr.inv;
        st_d.sticky_status[`DARS_B_AUS] = st_q.sticky_status[`DARS_B_AUS] | fr.unf;
        st_d.sticky_status[`DARS_B_AVS] = st_q.sticky_status[`DARS_B_AVS] | fr.ovf;
      end else if (req.op != OP_COMP && req.op != OP_FCOMP) begin
        st_d.rsp.res_a = fx_out(r32);
        st_d.fl.az = r32 == 32'h0;
        st_d.fl.an = r32[31];
        // flag from the value before clamping
        st_d.fl.av = st_d.fl.av | fovf;
        st_d.sticky_status[`DARS_B_AOS] = st_q.sticky_status[`DARS_B_AOS] | fovf;
      end
    end
    // software writes land after the alu update and so win
    if (bus.wr) begin
      if (bus.addr == `DARS_OFF_MODE) begin
        st_d.mode.sat = bus.wdata[`DARS_B_SAT];
        st_d.mode.round_to_zero_select = bus.wdata[`DARS_B_ROUND_TO_ZERO_SELECT];
        st_d.mode.nar = bus.wdata[`DARS_B_NARROW];
      end else if (bus.addr == `DARS_OFF_ARITH_STATUS) begin
        st_d.fl.compare_history = bus.wdata[`DARS_COMPARE_HISTORY_HI:`DARS_COMPARE_HISTORY_LO];
        st_d.fl.af = bus.wdata[`DARS_B_AF];
        st_d.fl.ai = bus.wdata[`DARS_B_AI];
        st_d.fl.as = bus.wdata[`DARS_B_AS];
        st_d.fl.ac = bus.wdata[`DARS_B_AC];
        st_d.fl.an = bus.wdata[`DARS_B_AN];
        st_d.fl.av = bus.wdata[`DARS_B_AV];
        st_d.fl.az = bus.wdata[`DARS_B_AZ];
      end else if (bus.addr == `DARS_OFF_STICKY_STATUS) begin
        st_d.sticky_status = bus.wdata[2:0];
      end
    end
    // read data shows the state before this cycle's update
    if (bus.rd) begin
      if (bus.addr == `DARS_OFF_MODE) begin
        st_d.rdata[`DARS_B_SAT] = st_q.mode.sat;
        st_d.rdata[`DARS_B_ROUND_TO_ZERO_SELECT] = st_q.mode.round_to_zero_select;
        st_d.rdata[`DARS_B_NARROW] = st_q.mode.nar;
      end else if (bus.addr == `DARS_OFF_ARITH_STATUS) begin
        st_d.rdata = arith_status_word(st_q.fl);
      end else if (bus.addr == `DARS_OFF_STICKY_STATUS) begin
        st_d.rdata = {29'h0, st_q.sticky_status};
      end
    end
  end

  // state register; flags show up the cycle after the op
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign rsp = st_q.rsp;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic no_aw; // no status write this cycle
  assign no_aw = !(bus.wr && bus.addr == `DARS_OFF_ARITH_STATUS);

  sequence s_cmp;
    req.valid && req.op == OP_COMP && no_aw;
  endsequence
  sequence s_shifted;
    st_q.fl.compare_history[6:0] == $past(st_q.fl.compare_history[7:1]) && st_q.fl.compare_history[7] == $past(fix_gt);
  endsequence

  a_cmp_history: assert property (s_cmp |=> s_shifted)
    else $error("compare history did not shift in x>y");
  a_compare_history_hold: assert property (req.op != OP_COMP && req.op != OP_FCOMP && no_aw
    |=> $stable(st_q.fl.compare_history))
    else $error("compare history moved without a compare");
  a_fix_low: assert property (req.valid && req.op inside {OP_ADD, OP_AND, OP_SIGNIFICAND_EXTRACT_OP, OP_BINARY_LOG_OP}
    |=> rsp.wr_a && rsp.res_a[7:0] == 8'h00)
    else $error("fixed result low byte not clear");
  a_wrap_upper: assert property (req.valid && req.op == OP_ADD && !st_q.mode.sat
    |=> rsp.res_a[39:8] == 32'($past(req.x[39:8]) + $past(req.y[39:8])))
    else $error("unsaturated sum differs from upper-word sum");
  a_sat_clamp: assert property (req.valid && req.op == OP_ADD && st_q.mode.sat && ov_a
    |=> rsp.res_a[39:8] == ($past(req.x[39]) ? `DARS_FIX_MIN : `DARS_FIX_MAX))
    else $error("saturated overflow not clamped");
  a_ovf_flag: assert property (req.valid && req.op == OP_ADD && ov_a && no_aw
    && !(bus.wr && bus.addr == `DARS_OFF_STICKY_STATUS) |=> st_q.fl.av && st_q.sticky_status[`DARS_B_AOS])
    else $error("overflow flag lost under saturation");
  a_narrow_out: assert property (req.valid && req.op inside {OP_FADD, OP_FSUB, OP_RND}
    && (st_q.mode.nar || req.op == OP_RND) |=> rsp.res_a[7:0] == 8'h00)
    else $error("narrow float result low byte set");
  a_cmp_nowrite: assert property (req.valid && req.op inside {OP_COMP, OP_FCOMP}
    |=> !rsp.wr_a && !rsp.wr_b)
    else $error("compare wrote a result");
  a_dual_result: assert property (req.valid && req.op == OP_ADDSUB |=> rsp.wr_a && rsp.wr_b)
    else $error("add/sub did not give two results");
  a_sticky_keep: assert property (!(bus.wr && bus.addr == `DARS_OFF_STICKY_STATUS)
    |=> (st_q.sticky_status & $past(st_q.sticky_status)) == $past(st_q.sticky_status))
    else $error("sticky flag fell without a write");
  a_sw_wins: assert property (bus.wr && bus.addr == `DARS_OFF_ARITH_STATUS
    |=> arith_status_word(st_q.fl) == ($past(bus.wdata) & `DARS_ARITH_STATUS_MASK))
    else $error("status write did not override");
  a_float_flag: assert property (req.valid && req.op == OP_FADD && no_aw ##1 1'h1
    |-> st_q.fl.af)
    else $error("float flag not set after float op");
endmodule : dars_alu
`default_nettype wire

/* tb/dars_rf_model.sv */
/*
  register file and sequencer model on the far side of the alu.
  assumes the bench loads slots 1 and 2 and strobes go for one cycle.
*/
`default_nettype none
module dars_rf_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire dars_pkg::dars_op_e op,
  input wire dars_pkg::dars_rsp_s rsp,
  output dars_pkg::dars_req_s req
);
  timeunit 1ns;
  timeprecision 1ns;
  import dars_pkg::*;
  logic [39:0] rf [5]; // slots 1,2 operands, 3,4 results
  // operands early in the cycle; idle cycles show junk so stale data never passes
  always_comb begin
    req.valid = go;
    req.op = op;
    req.x = go ? rf[1] : ~rf[1];
    req.y = go ? rf[2] : ~rf[2];
  end
  // write-back in the second half: taken at the edge after the answer
  always @(posedge ref_clk) begin
    if (rsp.wr_a) rf[3] <= rsp.res_a;
    if (rsp.wr_b) rf[4] <= rsp.res_b;
  end
endmodule : dars_rf_model
`default_nettype wire

/* tb/dars_alu_tb.sv */
/*
  self-checking bench of the alu block: registers, fixed, float, flags.
  assumes the register file model and a 20 MHz clock.
*/
`default_nettype none
module dars_alu_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dars_pkg::*;
  typedef struct packed {logic [31:0] m; dars_op_e o; logic [39:0] x, y, e;} dars_case_s;
  localparam logic [31:0] m_sat = 32'h0000_2000;
  localparam logic [31:0] m_trn = 32'h0000_8000;
  localparam logic [31:0] m_nar = 32'h0001_0000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  dars_op_e op = OP_ADD;
  dars_bus_s bus = '0;
  dars_req_s req;
  dars_rsp_s rsp;
  logic [31:0] reg_rdata, rv;
  logic [39:0] xa, ya;
  logic [7:0] hist;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'h698a;
  int cyc = 0;
  // float and fixed cases: mode, op, x, y, expected
  dars_case_s ft [15] = '{
    '{m_nar, OP_FADD, 40'h3F_8000_0000, 40'h33_8000_0000, 40'h3F_8000_0000}, // tie to even
    '{m_nar, OP_FADD, 40'h3F_8000_0000, 40'h33_C000_0000, 40'h3F_8000_0100}, // nearer
    '{m_nar | m_trn, OP_FADD, 40'h3F_8000_0000, 40'h33_C000_0000, 40'h3F_8000_0000},
    '{32'h0, OP_FADD, 40'h3F_8000_0000, 40'h33_C000_0000, 40'h3F_8000_00C0},
    '{m_nar, OP_FADD, 40'h7F_7FFF_FF00, 40'h73_0000_0000, 40'h7F_8000_0000},
    '{m_nar, OP_FLOAT, 40'h7F_FFFF_FF00, 40'h0, 40'h4E_FFFF_FFFE},
    '{m_nar, OP_FPASS, 40'h3F_8000_00FF, 40'h0, 40'h3F_8000_0000},
    '{m_nar, OP_FADD, 40'hFF_7FFF_FF00, 40'hF3_0000_0000, 40'hFF_8000_0000}, // negative side
    '{32'h0, OP_RND, 40'h3F_8000_0180, 40'h0, 40'h3F_8000_0200}, // round op, full input
    '{32'h0, OP_FSUB, 40'h40_0000_0000, 40'h3F_8000_0000, 40'h3F_8000_0000},
    '{m_trn, OP_FRND, 40'h00_0000_0300, 40'h80_0000_0000, 40'h00_0000_0400}, // nearest only
    '{32'h0, OP_SUB, 40'h00_0000_0300, 40'h00_0000_0500, 40'hFF_FFFF_FE00},
    '{m_sat, OP_ABS, 40'h80_0000_0000, 40'h0, 40'h7F_FFFF_FF00},
    '{32'h0, OP_SIGNIFICAND_EXTRACT_OP, 40'h3F_C000_0000, 40'h0, 40'hC0_0000_0000},
    '{32'h0, OP_BINARY_LOG_OP, 40'h40_0000_0000, 40'h0, 40'h00_0000_0100}};
  // compares: e holds whether x exceeds y
  dars_case_s cx [4] = '{
    '{32'h0, OP_COMP, 40'h00_0000_0500, 40'h00_0000_0300, 40'h1},
    '{32'h0, OP_COMP, 40'h00_0000_0300, 40'h00_0000_0500, 40'h0},
    '{32'h0, OP_COMP, 40'h80_0000_0000, 40'h00_0000_0100, 40'h0}, // signed view
    '{32'h0, OP_FCOMP, 40'h40_0000_0000, 40'h3F_8000_0000, 40'h1}};
  always #25 ref_clk = ~ref_clk;
  dars_alu i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .reg_rdata(reg_rdata), .req(req), .rsp(rsp));
  dars_rf_model i_rf (.ref_clk(ref_clk), .go(go), .op(op), .rsp(rsp), .req(req));
  // hang guard, far above the roughly 175 cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = reg_rdata;
  endtask : rd
  // one op; cw adds a register clear in the same cycle
  task automatic run(input dars_op_e o, input logic [39:0] x, y, input logic cw = 1'b0, input logic [7:0] ca = 8'h0);
    i_rf.rf[1] <= x;
    i_rf.rf[2] <= y;
    @(posedge ref_clk);
    go <= 1'b1;
    op <= o;
    bus <= '{cw, 1'b0, ca, 32'h0};
    @(posedge ref_clk);
    go <= 1'b0;
    bus <= '0;
    #1;
  endtask : run
  // expected af,ai,as,ac,an,av,az of a fixed add
  function automatic logic [6:0] afl(input logic [39:0] x, input logic [39:0] y);
    logic [32:0] s;
    s = {1'b0, x[39:8]} + {1'b0, y[39:8]};
    return {3'b000, s[32], s[31], (x[39] == y[39]) && (s[31] != x[39]), s[31:0] == 32'h0};
  endfunction : afl
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, rv);
    chk(rv, m_sat | m_trn | m_nar);
    rd(8'h0C, rv);
    chk(rv, 40'h0);
    $display("test registers done");
    wr(8'h00, 32'h0);
    repeat (16) begin
      xa = {$random(seed), 8'($random(seed))};
      ya = {$random(seed), 8'($random(seed))};
      run(OP_ADD, xa, ya);
      chk(rsp.res_a, {xa[39:8] + ya[39:8], 8'h00});
      rd(8'h04, rv);
      chk({rv[10], rv[5:0]}, afl(xa, ya));
    end
    $display("test fixed add done");
    wr(8'h08, 32'h0);
    wr(8'h00, m_sat);
    run(OP_ADD, 40'h7F_FFFF_FF3C, 40'h00_0000_0100);
    chk(rsp.res_a, 40'h7F_FFFF_FF00);
    rd(8'h04, rv);
    chk(rv[1], 1'b1);
    run(OP_ADD, 40'h80_0000_0000, 40'hFF_FFFF_FF00);
    chk(rsp.res_a, 40'h80_0000_0000);
    wr(8'h00, 32'h0);
    run(OP_ADD, 40'h7F_FFFF_FF00, 40'h00_0000_0100);
    chk(rsp.res_a, 40'h80_0000_0000);
    run(OP_AND, 40'h0, 40'h0);
    rd(8'h08, rv);
    chk(rv, 40'h4);
    run(OP_ADD, 40'h7F_FFFF_FF00, 40'h00_0000_0100, 1'b1, 8'h08);
    rd(8'h08, rv);
    chk(rv, 40'h0);
    $display("test saturation done");
    wr(8'h04, 32'h0);
    hist = 8'h00;
    for (int i = 0; i < 4; i++) begin
      run(cx[i].o, cx[i].x, cx[i].y);
      chk(rsp.wr_a, 1'b0);
      hist = {cx[i].e[0], hist[7:1]};
    end
    rd(8'h04, rv);
    chk(rv[31:24], hist);
    run(OP_ADDSUB, 40'h00_0000_0500, 40'h00_0000_0300);
    chk({rsp.wr_a, rsp.wr_b, rsp.res_b}, {2'b11, 40'h00_0000_0200});
    $display("test compare done");
    for (int i = 0; i < 15; i++) begin
      wr(8'h00, ft[i].m);
      run(ft[i].o, ft[i].x, ft[i].y);
      chk(rsp.res_a, ft[i].e);
    end
    $display("test float done");
    summarize();
  end
endmodule : dars_alu_tb
`default_nettype wire
